// ### prs_periph_model.sv
// Peripheral model: live interrupt sources, counter snapshots and calibration status
`timescale 1ns/1ns
module prs_periph_model #(
  parameter logic [31:0] SRC_LEVEL = 32'h00003080,
  parameter logic [31:0] CNT_SNAP  = 32'h0badcafe
) (
  // Clock and snapshot request
  input  wire logic   core_clk,
  input  wire logic   snap,
  // Live state toward the register space
  output logic [31:0] hw_sources,
  output logic [31:0] cnt,
  output logic        count_load,
  output logic [7:0]  boc_status,
  output logic        boc_status_load
);
  // Load strobes follow a snapshot request by one cycle
  always_ff @(posedge core_clk) begin
    count_load      <= snap;
    boc_status_load <= snap;
  end
  // Outside the load cycle the values are inverted so a stale capture shows up
  assign cnt        = count_load ? CNT_SNAP : ~CNT_SNAP;
  assign boc_status = boc_status_load ? 8'h03 : 8'hfc;
  assign hw_sources = SRC_LEVEL;
endmodule

// ### prs_pkg.sv
// Package: address map, reset values and bus types for the peripheral register space
package prs_pkg;

  localparam logic [31:0] BASE_ADDR   = 32'hffff0000; // lowest group, top 4 kB
  localparam logic [31:0] SPACE_MASK  = 32'hfffff000;

  localparam logic [11:0] OFS_IRQ_STA    = 12'h000;
  localparam logic [11:0] OFS_IRQ_RAW    = 12'h004;
  localparam logic [11:0] OFS_IRQ_EN     = 12'h008;
  localparam logic [11:0] OFS_IRQ_DIS    = 12'h00c;
  localparam logic [11:0] OFS_SWI_CFG    = 12'h010;
  localparam logic [11:0] OFS_FIQ_STA    = 12'h100;
  localparam logic [11:0] OFS_FIQ_RAW    = 12'h104;
  localparam logic [11:0] OFS_FIQ_EN     = 12'h108;
  localparam logic [11:0] OFS_FIQ_DIS    = 12'h10c;
  localparam logic [11:0] OFS_REMAP      = 12'h220;
  localparam logic [11:0] OFS_RST_STA    = 12'h230;
  localparam logic [11:0] OFS_RST_CLR    = 12'h234;
  localparam logic [11:0] OFS_CHKSUM     = 12'h244;
  localparam logic [11:0] OFS_T0_RELOAD  = 12'h300;
  localparam logic [11:0] OFS_T0_COUNT   = 12'h304;
  localparam logic [11:0] OFS_T0_CTRL    = 12'h308;
  localparam logic [11:0] OFS_T0_ACK     = 12'h30c;
  localparam logic [11:0] OFS_T1_RELOAD  = 12'h320;
  localparam logic [11:0] OFS_T1_COUNT   = 12'h324;
  localparam logic [11:0] OFS_T1_CTRL    = 12'h328;
  localparam logic [11:0] OFS_T1_ACK     = 12'h32c;
  localparam logic [11:0] OFS_T2_RELOAD  = 12'h340;
  localparam logic [11:0] OFS_T2_COUNT   = 12'h344;
  localparam logic [11:0] OFS_T2_CTRL    = 12'h348;
  localparam logic [11:0] OFS_T2_ACK     = 12'h34c;
  localparam logic [11:0] OFS_SYNTH_STA  = 12'h400;
  localparam logic [11:0] OFS_POW_PREKEY = 12'h404;
  localparam logic [11:0] OFS_POW_CTRL   = 12'h408;
  localparam logic [11:0] OFS_POW_POSTKEY = 12'h40c;
  localparam logic [11:0] OFS_CLK_PREKEY = 12'h410;
  localparam logic [11:0] OFS_CLK_SEL    = 12'h414;
  localparam logic [11:0] OFS_CLK_POSTKEY = 12'h418;
  localparam logic [11:0] OFS_LPC_CTRL   = 12'h440;
  localparam logic [11:0] OFS_LPC_STA    = 12'h444;
  localparam logic [11:0] OFS_LPC_CNT0   = 12'h448;
  localparam logic [11:0] OFS_LPC_CNT1   = 12'h44c;
  localparam logic [11:0] OFS_BOC_CTRL   = 12'h480;
  localparam logic [11:0] OFS_LP_TRIM    = 12'h484;
  localparam logic [11:0] OFS_PR_TRIM    = 12'h488;
  localparam logic [11:0] OFS_BOC_UPPER  = 12'h48c;
  localparam logic [11:0] OFS_BOC_LOWER  = 12'h490;
  localparam logic [11:0] OFS_BOC_STA    = 12'h494;
  localparam logic [11:0] OFS_LP_TRIMV   = 12'h498;
  localparam logic [11:0] OFS_PR_TRIMV   = 12'h49c;
  localparam logic [11:0] OFS_BOC_LOCK   = 12'h4a0;

  localparam logic [31:0] RST_IRQ_RAW  = 32'h00003080;
  localparam logic [31:0] RST_FIQ_RAW  = 32'h00003081;
  localparam logic [31:0] RST_T1_COUNT = 32'hffffffff;
  localparam logic [31:0] RST_T2_COUNT = 32'h00000050;
  localparam logic [31:0] RST_T2_RELOAD = 32'h00000050;
  localparam logic [15:0] RST_POW_CTRL = 16'h0079;
  localparam logic [7:0]  RST_BOC_STA  = 8'h01;

  // Transfer size codes from the core
  typedef enum logic [1:0] {
    PRS_SZ_BYTE = 2'h0,
    PRS_SZ_HALF = 2'h1,
    PRS_SZ_WORD = 2'h2
  } prs_size_t;

  // One core load/store request
  typedef struct packed {
    logic        valid;
    logic        write;
    prs_size_t   size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } prs_req_t;

  // Key sequence tracker states, Gray coded
  typedef enum logic [1:0] {
    PRS_KEY_IDLE = 2'b00,
    PRS_KEY_PRE  = 2'b01,
    PRS_KEY_DATA = 2'b11
  } prs_key_t;

endpackage

// ### prs_regs.sv
// Peripheral register space: decode, storage and read alignment for the core load/store path
`timescale 1ns/1ns
// Notes on behaviour
// - Space decoded in top 4 kB, lowest group at 0xffff0000.
// - Every register accepts a full 32-bit read or write.
// - Narrow register read data sits in the low byte lanes, little-endian.
// - Halfword write to a 32-bit register zeroes its upper 16 bits.
// - Halfword read of a 32-bit register returns only sixteen bits.
// - Read-only registers ignore writes; write-only registers read as zero.
// - All peripheral control and status registers live in this space.
// - Raw-source registers read-only, resets 0x3080 normal and 0x3081 fast.
// - Enable registers reset to zero; disable registers clear written enable bits.
// - Write-only soft interrupt config at 0x010 raises interrupt sources.
// - 24-bit upper and lower tolerance registers, read-write, reset to zero.
// - Write-only calibration lock at 0x4a0; calibration status resets to 0x01.
// - Clock select byte wide, reset 0x00, keyed by 0x410 and 0x418.
// - Timer counts read-only; resets 0x0000, 0xffffffff and 0x00000050.
// - Low-power calibration counters at 0x448 and 0x44c read-only, reset zero.
module prs_regs #(
  parameter int NUM_SRC = 32
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // Core load/store request
  input  wire prs_pkg::prs_req_t req,
  output logic                   ack,
  output logic [31:0]            rdata,
  // Peripheral live state
  input  wire logic [31:0]       hw_sources,
  input  wire logic [15:0]       t0_count_in,
  input  wire logic [31:0]       t1_count_in,
  input  wire logic [31:0]       t2_count_in,
  input  wire logic              count_load,
  input  wire logic [31:0]       synth_status,
  input  wire logic [7:0]        lpc_status,
  input  wire logic [15:0]       lpc_count0_in,
  input  wire logic [15:0]       lpc_count1_in,
  input  wire logic [7:0]        boc_status_in,
  input  wire logic              boc_status_load,
  input  wire logic [7:0]        lp_trim_value,
  input  wire logic [15:0]       pr_trim_value,
  // Control outputs
  output logic [31:0]            irq_active,
  output logic [31:0]            fiq_active,
  output logic [15:0]            power_ctrl_out,
  output logic [7:0]             clock_sel_out,
  output logic [23:0]            boc_upper_out,
  output logic [23:0]            boc_lower_out,
  output logic                   boc_locked,
  output logic [7:0]             remap_out,
  output logic [2:0]             timer_irq_ack
);

  logic        in_space;
  logic        wr;
  logic [11:0] ofs;
  logic [31:0] wd;
  logic [31:0] rd_next;
  logic [31:0] irq_en_reg, fiq_en_reg, swi_reg, chk_reg, t1_ld_reg, t2_ld_reg;
  logic [31:0] t0_ctl_reg, t1_ctl_reg, t1_cnt_reg, t2_cnt_reg, raw_reg;
  logic [15:0] t0_ld_reg, t2_ctl_reg, pow_reg, t0_cnt_reg, lpc0_reg, lpc1_reg, pr_trim_reg;
  logic [7:0]  map_reg, rst_sta_reg, clk_reg, lpc_ctl_reg, boc_ctl_reg, lp_trim_reg, boc_sta_reg;
  logic [23:0] upper_reg, lower_reg;
  logic        lock_reg;
  prs_pkg::prs_key_t pow_key_reg, clk_key_reg;
  logic [15:0] pow_pend_reg;
  logic [7:0]  clk_pend_reg;

  // Decode the top 4 kB window only
  assign in_space = (req.addr & prs_pkg::SPACE_MASK) == prs_pkg::BASE_ADDR;
  assign ofs      = req.addr[11:0];
  assign wr       = req.valid && req.write && in_space;
  assign ack      = req.valid;

  // Halfword stores clear the upper half of wide registers
  assign wd = (req.size == prs_pkg::PRS_SZ_WORD) ? req.wdata
            : (req.size == prs_pkg::PRS_SZ_HALF) ? {16'h0000, req.wdata[15:0]}
            : {24'h000000, req.wdata[7:0]};

  function automatic logic hit(input logic [11:0] o, input logic [11:0] r);
    hit = (o == r);
  endfunction

  // Interrupt enable banks; an enable write replaces the bank, a disable write clears the bits written
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_reg <= 32'h00000000;
      fiq_en_reg <= 32'h00000000;
      swi_reg    <= 32'h00000000;
    end else if (wr) begin
      if (hit(ofs, prs_pkg::OFS_IRQ_EN)) irq_en_reg <= wd;
      else if (hit(ofs, prs_pkg::OFS_IRQ_DIS)) irq_en_reg <= irq_en_reg & ~wd;
      else if (hit(ofs, prs_pkg::OFS_FIQ_EN)) fiq_en_reg <= wd;
      else if (hit(ofs, prs_pkg::OFS_FIQ_DIS)) fiq_en_reg <= fiq_en_reg & ~wd;
      else if (hit(ofs, prs_pkg::OFS_SWI_CFG)) swi_reg <= wd;
    end
  end

  // Raw sources: hardware lines plus software raised bits
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      raw_reg <= prs_pkg::RST_IRQ_RAW;
    end else begin
      raw_reg <= hw_sources | swi_reg;
    end
  end

  // Active sources are raw gated by each bank's enable
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_active <= 32'h00000000;
      fiq_active <= 32'h00000000;
    end else begin
      irq_active <= raw_reg & irq_en_reg;
      fiq_active <= (raw_reg | 32'h00000001) & fiq_en_reg; // Same view as the fast raw read
    end
  end

  // System control, timer setup and trim storage
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      map_reg <= 8'h00; rst_sta_reg <= 8'h00; chk_reg <= 32'h00000000;
      t0_ld_reg <= 16'h0000; t0_ctl_reg <= 32'h00000000; t1_ld_reg <= 32'h00000000;
      t1_ctl_reg <= 32'h00000000; t2_ld_reg <= prs_pkg::RST_T2_RELOAD; t2_ctl_reg <= 16'h0000;
      lpc_ctl_reg <= 8'h00; boc_ctl_reg <= 8'h00; lp_trim_reg <= 8'h00; pr_trim_reg <= 16'h0000;
      upper_reg <= 24'h000000; lower_reg <= 24'h000000;
    end else if (wr && !lock_reg) begin
      if (hit(ofs, prs_pkg::OFS_REMAP)) map_reg <= wd[7:0];
      else if (hit(ofs, prs_pkg::OFS_RST_STA)) rst_sta_reg <= rst_sta_reg | wd[7:0];
      else if (hit(ofs, prs_pkg::OFS_RST_CLR)) rst_sta_reg <= rst_sta_reg & ~wd[7:0];
      else if (hit(ofs, prs_pkg::OFS_CHKSUM)) chk_reg <= wd;
      else if (hit(ofs, prs_pkg::OFS_T0_RELOAD)) t0_ld_reg <= wd[15:0];
      else if (hit(ofs, prs_pkg::OFS_T0_CTRL)) t0_ctl_reg <= wd;
      else if (hit(ofs, prs_pkg::OFS_T1_RELOAD)) t1_ld_reg <= wd;
      else if (hit(ofs, prs_pkg::OFS_T1_CTRL)) t1_ctl_reg <= wd;
      else if (hit(ofs, prs_pkg::OFS_T2_RELOAD)) t2_ld_reg <= wd;
      else if (hit(ofs, prs_pkg::OFS_T2_CTRL)) t2_ctl_reg <= wd[15:0];
      else if (hit(ofs, prs_pkg::OFS_LPC_CTRL)) lpc_ctl_reg <= wd[7:0];
      else if (hit(ofs, prs_pkg::OFS_BOC_CTRL)) boc_ctl_reg <= wd[7:0];
      else if (hit(ofs, prs_pkg::OFS_LP_TRIM)) lp_trim_reg <= wd[7:0];
      else if (hit(ofs, prs_pkg::OFS_PR_TRIM)) pr_trim_reg <= wd[15:0];
      else if (hit(ofs, prs_pkg::OFS_BOC_UPPER)) upper_reg <= wd[23:0];
      else if (hit(ofs, prs_pkg::OFS_BOC_LOWER)) lower_reg <= wd[23:0];
    end
  end

  // Calibration lock: once written, trim and window writes are frozen until reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_reg <= 1'b0;
    end else if (wr && hit(ofs, prs_pkg::OFS_BOC_LOCK)) begin
      lock_reg <= 1'b1;
    end
  end

  // Timer ack strobes, one cycle per write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_irq_ack <= 3'h0;
    end else begin
      timer_irq_ack <= {wr && hit(ofs, prs_pkg::OFS_T2_ACK), wr && hit(ofs, prs_pkg::OFS_T1_ACK),
                        wr && hit(ofs, prs_pkg::OFS_T0_ACK)};
    end
  end

  // Read-only captures of peripheral state; bus writes never reach these
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      t0_cnt_reg <= 16'h0000;
      t1_cnt_reg <= prs_pkg::RST_T1_COUNT;
      t2_cnt_reg <= prs_pkg::RST_T2_COUNT;
      lpc0_reg   <= 16'h0000;
      lpc1_reg   <= 16'h0000;
    end else if (count_load) begin
      t0_cnt_reg <= t0_count_in;
      t1_cnt_reg <= t1_count_in;
      t2_cnt_reg <= t2_count_in;
      lpc0_reg   <= lpc_count0_in;
      lpc1_reg   <= lpc_count1_in;
    end
  end

  // Calibration status capture
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      boc_sta_reg <= prs_pkg::RST_BOC_STA;
    end else if (boc_status_load) begin
      boc_sta_reg <= boc_status_in;
    end
  end

  // Power control key sequence: prekey, data, then postkey commits
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pow_key_reg  <= prs_pkg::PRS_KEY_IDLE;
      pow_pend_reg <= 16'h0000;
      pow_reg      <= prs_pkg::RST_POW_CTRL;
    end else if (wr) begin
      case (pow_key_reg)
        prs_pkg::PRS_KEY_IDLE: begin
          if (hit(ofs, prs_pkg::OFS_POW_PREKEY)) pow_key_reg <= prs_pkg::PRS_KEY_PRE;
        end
        prs_pkg::PRS_KEY_PRE: begin
          if (hit(ofs, prs_pkg::OFS_POW_CTRL)) begin
            pow_pend_reg <= wd[15:0];
            pow_key_reg  <= prs_pkg::PRS_KEY_DATA;
          end else begin
            pow_key_reg  <= prs_pkg::PRS_KEY_IDLE;
          end
        end
        prs_pkg::PRS_KEY_DATA: begin
          if (hit(ofs, prs_pkg::OFS_POW_POSTKEY)) pow_reg <= pow_pend_reg;
          pow_key_reg <= prs_pkg::PRS_KEY_IDLE;
        end
        default: pow_key_reg <= prs_pkg::PRS_KEY_IDLE;
      endcase
    end
  end

  // Clock source select key sequence, same scheme
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_key_reg  <= prs_pkg::PRS_KEY_IDLE;
      clk_pend_reg <= 8'h00;
      clk_reg      <= 8'h00;
    end else if (wr) begin
      case (clk_key_reg)
        prs_pkg::PRS_KEY_IDLE: begin
          if (hit(ofs, prs_pkg::OFS_CLK_PREKEY)) clk_key_reg <= prs_pkg::PRS_KEY_PRE;
        end
        prs_pkg::PRS_KEY_PRE: begin
          if (hit(ofs, prs_pkg::OFS_CLK_SEL)) begin
            clk_pend_reg <= wd[7:0];
            clk_key_reg  <= prs_pkg::PRS_KEY_DATA;
          end else begin
            clk_key_reg  <= prs_pkg::PRS_KEY_IDLE;
          end
        end
        prs_pkg::PRS_KEY_DATA: begin
          if (hit(ofs, prs_pkg::OFS_CLK_POSTKEY)) clk_reg <= clk_pend_reg;
          clk_key_reg <= prs_pkg::PRS_KEY_IDLE;
        end
        default: clk_key_reg <= prs_pkg::PRS_KEY_IDLE;
      endcase
    end
  end

  // Read mux; narrow registers zero-extended into low lanes, write-only and holes read zero
  always_comb begin
    rd_next = 32'h00000000;
    if (!in_space) rd_next = 32'h00000000;
    else if (hit(ofs, prs_pkg::OFS_IRQ_STA)) rd_next = irq_active;
    else if (hit(ofs, prs_pkg::OFS_IRQ_RAW)) rd_next = raw_reg;
    else if (hit(ofs, prs_pkg::OFS_IRQ_EN)) rd_next = irq_en_reg;
    else if (hit(ofs, prs_pkg::OFS_FIQ_STA)) rd_next = fiq_active;
    else if (hit(ofs, prs_pkg::OFS_FIQ_RAW)) rd_next = raw_reg | 32'h00000001;
    else if (hit(ofs, prs_pkg::OFS_FIQ_EN)) rd_next = fiq_en_reg;
    else if (hit(ofs, prs_pkg::OFS_REMAP)) rd_next = {24'h000000, map_reg};
    else if (hit(ofs, prs_pkg::OFS_RST_STA)) rd_next = {24'h000000, rst_sta_reg};
    else if (hit(ofs, prs_pkg::OFS_CHKSUM)) rd_next = chk_reg;
    else if (hit(ofs, prs_pkg::OFS_T0_RELOAD)) rd_next = {16'h0000, t0_ld_reg};
    else if (hit(ofs, prs_pkg::OFS_T0_COUNT)) rd_next = {16'h0000, t0_cnt_reg};
    else if (hit(ofs, prs_pkg::OFS_T0_CTRL)) rd_next = t0_ctl_reg;
    else if (hit(ofs, prs_pkg::OFS_T1_RELOAD)) rd_next = t1_ld_reg;
    else if (hit(ofs, prs_pkg::OFS_T1_COUNT)) rd_next = t1_cnt_reg;
    else if (hit(ofs, prs_pkg::OFS_T1_CTRL)) rd_next = t1_ctl_reg;
    else if (hit(ofs, prs_pkg::OFS_T2_RELOAD)) rd_next = t2_ld_reg;
    else if (hit(ofs, prs_pkg::OFS_T2_COUNT)) rd_next = t2_cnt_reg;
    else if (hit(ofs, prs_pkg::OFS_T2_CTRL)) rd_next = {16'h0000, t2_ctl_reg};
    else if (hit(ofs, prs_pkg::OFS_SYNTH_STA)) rd_next = synth_status;
    else if (hit(ofs, prs_pkg::OFS_POW_CTRL)) rd_next = {16'h0000, pow_reg};
    else if (hit(ofs, prs_pkg::OFS_CLK_SEL)) rd_next = {24'h000000, clk_reg};
    else if (hit(ofs, prs_pkg::OFS_LPC_CTRL)) rd_next = {24'h000000, lpc_ctl_reg};
    else if (hit(ofs, prs_pkg::OFS_LPC_STA)) rd_next = {24'h000000, lpc_status};
    else if (hit(ofs, prs_pkg::OFS_LPC_CNT0)) rd_next = {16'h0000, lpc0_reg};
    else if (hit(ofs, prs_pkg::OFS_LPC_CNT1)) rd_next = {16'h0000, lpc1_reg};
    else if (hit(ofs, prs_pkg::OFS_BOC_CTRL)) rd_next = {24'h000000, boc_ctl_reg};
    else if (hit(ofs, prs_pkg::OFS_LP_TRIM)) rd_next = {24'h000000, lp_trim_reg};
    else if (hit(ofs, prs_pkg::OFS_PR_TRIM)) rd_next = {16'h0000, pr_trim_reg};
    else if (hit(ofs, prs_pkg::OFS_BOC_UPPER)) rd_next = {8'h00, upper_reg};
    else if (hit(ofs, prs_pkg::OFS_BOC_LOWER)) rd_next = {8'h00, lower_reg};
    else if (hit(ofs, prs_pkg::OFS_BOC_STA)) rd_next = {24'h000000, boc_sta_reg};
    else if (hit(ofs, prs_pkg::OFS_LP_TRIMV)) rd_next = {24'h000000, lp_trim_value};
    else if (hit(ofs, prs_pkg::OFS_PR_TRIMV)) rd_next = {16'h0000, pr_trim_value};
  end

  // Registered read data; narrow loads see only the low lanes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h00000000;
    end else if (req.valid && !req.write) begin
      if (req.size == prs_pkg::PRS_SZ_HALF) rdata <= {16'h0000, rd_next[15:0]};
      else if (req.size == prs_pkg::PRS_SZ_BYTE) rdata <= {24'h000000, rd_next[7:0]};
      else rdata <= rd_next;
    end
  end

  // Control outputs
  assign power_ctrl_out = pow_reg;
  assign clock_sel_out  = clk_reg;
  assign boc_upper_out  = upper_reg;
  assign boc_lower_out  = lower_reg;
  assign boc_locked     = lock_reg;
  assign remap_out      = map_reg;

endmodule

// ### prs_regs_checker.sv
// Checker: bus timing and keyed/locked register behaviour of the peripheral register space
`timescale 1ns/1ns
module prs_regs_checker (
  // Clock and reset
  input wire logic              core_clk,
  input wire logic              rst_n,
  // Core access and results
  input wire prs_pkg::prs_req_t req,
  input wire logic              ack,
  input wire logic [31:0]       rdata,
  // Control outputs
  input wire logic [15:0]       power_ctrl_out,
  input wire logic [7:0]        clock_sel_out,
  input wire logic [23:0]       boc_upper_out,
  input wire logic              boc_locked,
  input wire logic [2:0]        timer_irq_ack
);
  logic        rd;
  logic        wr;
  logic [11:0] ofs;
  // Only accesses inside the 4 kB window count as register traffic
  assign rd  = req.valid && !req.write && ((req.addr & prs_pkg::SPACE_MASK) == prs_pkg::BASE_ADDR);
  assign wr  = req.valid && req.write && ((req.addr & prs_pkg::SPACE_MASK) == prs_pkg::BASE_ADDR);
  assign ofs = req.addr[11:0];

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_ack_same_cycle: assert property (ack == req.valid) else $error("ack not equal to request valid");
  a_hole_reads_zero: assert property (rd && ofs == 12'h014 |=> rdata == 32'h0) else $error("hole read not zero");
  a_wo_reads_zero: assert property (
    rd && (ofs == prs_pkg::OFS_IRQ_DIS || ofs == prs_pkg::OFS_BOC_LOCK) |=> rdata == 32'h0)
    else $error("write-only register read not zero");
  a_byte_low_lane: assert property (rd && req.size == prs_pkg::PRS_SZ_BYTE |=> rdata[31:8] == 24'h0)
    else $error("byte read spills above low lane");
  a_half_sixteen: assert property (rd && req.size == prs_pkg::PRS_SZ_HALF |=> rdata[31:16] == 16'h0)
    else $error("half read returns more than sixteen bits");
  a_rdata_holds: assert property (!(req.valid && !req.write) |=> $stable(rdata)) else $error("read data moved");
  a_lock_sets: assert property (wr && ofs == prs_pkg::OFS_BOC_LOCK |=> boc_locked) else $error("lock not set");
  a_lock_freezes: assert property (boc_locked |=> boc_locked && $stable(boc_upper_out))
    else $error("lock dropped or tolerance changed");
  a_clock_keyed: assert property (
    $changed(clock_sel_out) |-> $past(wr) && $past(ofs) == prs_pkg::OFS_CLK_POSTKEY)
    else $error("clock select changed without post key");
  a_power_keyed: assert property (
    $changed(power_ctrl_out) |-> $past(wr) && $past(ofs) == prs_pkg::OFS_POW_POSTKEY)
    else $error("power control changed without post key");
  a_timer_ack: assert property (
    wr && ofs == prs_pkg::OFS_T0_ACK |=> timer_irq_ack == 3'b001 ##1 timer_irq_ack == 3'b000)
    else $error("timer ack pulse wrong");

  // Main scenarios reached
  c_keyed: cover property (wr && ofs == prs_pkg::OFS_CLK_POSTKEY);
  c_half_read: cover property (rd && req.size == prs_pkg::PRS_SZ_HALF);
  c_locked: cover property ($rose(boc_locked));
endmodule

bind prs_regs prs_regs_checker i_chk (.core_clk(core_clk), .rst_n(rst_n), .req(req), .ack(ack), .rdata(rdata),
  .power_ctrl_out(power_ctrl_out), .clock_sel_out(clock_sel_out), .boc_upper_out(boc_upper_out),
  .boc_locked(boc_locked), .timer_irq_ack(timer_irq_ack));

// ### tb_peripheral_register_space.sv
// Testbench: register access sequences against the peripheral register space
`timescale 1ns/1ns
module tb_peripheral_register_space;
  localparam prs_pkg::prs_size_t SZW = prs_pkg::PRS_SZ_WORD;
  localparam prs_pkg::prs_size_t SZH = prs_pkg::PRS_SZ_HALF;
  localparam prs_pkg::prs_size_t SZB = prs_pkg::PRS_SZ_BYTE;
  localparam logic [31:0] SNAP = 32'h0badcafe;
  localparam logic [11:0] RO_OFS [15] = '{12'h004, 12'h104, 12'h008, 12'h108, 12'h304, 12'h324, 12'h344, 12'h340,
    12'h494, 12'h408, 12'h414, 12'h48c, 12'h490, 12'h448, 12'h00c};
  localparam logic [31:0] RO_EXP [15] = '{32'h3080, 32'h3081, 32'h0, 32'h0, 32'h0, 32'hffffffff, 32'h50, 32'h50,
    32'h01, 32'h79, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  logic              core_clk, rst_n, snap, ack, count_load, boc_status_load, boc_locked;
  prs_pkg::prs_req_t req;
  logic [31:0]       rdata, hw_sources, cnt, irq_active, fiq_active, rd;
  logic [15:0]       power_ctrl_out;
  logic [7:0]        clock_sel_out, boc_status, remap_out;
  logic [23:0]       boc_upper_out, boc_lower_out;
  logic [2:0]        timer_irq_ack;
  int                fails, compares, cycles;

  prs_regs i_dut (.core_clk(core_clk), .rst_n(rst_n), .req(req), .ack(ack), .rdata(rdata),
    .hw_sources(hw_sources), .t0_count_in(cnt[15:0]), .t1_count_in(cnt), .t2_count_in(cnt),
    .count_load(count_load), .synth_status(cnt), .lpc_status(boc_status), .lpc_count0_in(cnt[15:0]),
    .lpc_count1_in(cnt[31:16]), .boc_status_in(boc_status), .boc_status_load(boc_status_load),
    .lp_trim_value(cnt[7:0]), .pr_trim_value(cnt[15:0]), .irq_active(irq_active), .fiq_active(fiq_active),
    .power_ctrl_out(power_ctrl_out), .clock_sel_out(clock_sel_out), .boc_upper_out(boc_upper_out),
    .boc_lower_out(boc_lower_out), .boc_locked(boc_locked), .remap_out(remap_out), .timer_irq_ack(timer_irq_ack));
  prs_periph_model #(.CNT_SNAP(SNAP)) i_model (.core_clk(core_clk), .snap(snap), .hw_sources(hw_sources),
    .cnt(cnt), .count_load(count_load), .boc_status(boc_status), .boc_status_load(boc_status_load));

  // Free-running 250 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic wrap_up();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  // One core access: request held until the taking edge, read data picked up after it
  task automatic acc(input logic w, input prs_pkg::prs_size_t sz, input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    req <= '{1'b1, w, sz, a, d};
    @(negedge core_clk);
    chk(32'h1, {31'h0, ack});
    @(posedge core_clk);
    req.valid <= 1'b0;
    #1 rd = rdata;
  endtask

  task automatic wr(input logic [11:0] o, input logic [31:0] d);
    acc(1'b1, SZW, prs_pkg::BASE_ADDR | {20'h0, o}, d);
  endtask

  task automatic rc(input logic [11:0] o, input prs_pkg::prs_size_t sz, input logic [31:0] exp);
    acc(1'b0, sz, prs_pkg::BASE_ADDR | {20'h0, o}, 32'h0);
    chk(exp, rd);
  endtask

  task automatic key(input logic [11:0] pre, input logic [11:0] o, input logic [11:0] post, input logic [31:0] d);
    wr(pre, 32'h0);
    wr(o, d);
    wr(post, 32'h0);
  endtask

  // Hang guard, generous against roughly 150 cycles of traffic
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      wrap_up();
    end
  end

  initial begin
    rst_n = 1'b0;
    snap = 1'b0;
    req = '0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 15; i++) rc(RO_OFS[i], SZW, RO_EXP[i]);
    $display("test reset_values done");
    wr(prs_pkg::OFS_IRQ_EN, 32'h0000ffff);
    rc(prs_pkg::OFS_IRQ_EN, SZW, 32'h0000ffff);
    wr(prs_pkg::OFS_IRQ_DIS, 32'h000000ff);
    rc(prs_pkg::OFS_IRQ_EN, SZW, 32'h0000ff00);
    chk(32'h00003000, irq_active);
    wr(prs_pkg::OFS_FIQ_EN, 32'hffffffff);
    wr(prs_pkg::OFS_FIQ_DIS, 32'hfffffffe);
    rc(prs_pkg::OFS_FIQ_EN, SZW, 32'h1);
    chk(32'h1, fiq_active);
    wr(prs_pkg::OFS_SWI_CFG, 32'h00010000);
    rc(prs_pkg::OFS_IRQ_RAW, SZW, 32'h00013080);
    $display("test interrupt_banks done");
    wr(prs_pkg::OFS_BOC_UPPER, 32'hffffffff);
    rc(prs_pkg::OFS_BOC_UPPER, SZW, 32'h00ffffff);
    chk(32'h00ffffff, {8'h0, boc_upper_out});
    rc(prs_pkg::OFS_BOC_UPPER, SZB, 32'h000000ff);
    wr(prs_pkg::OFS_BOC_LOWER, 32'h00abcdef);
    rc(prs_pkg::OFS_BOC_LOWER, SZH, 32'h0000cdef);
    chk(32'h00abcdef, {8'h0, boc_lower_out});
    wr(prs_pkg::OFS_CHKSUM, 32'haaaa5555);
    acc(1'b1, SZH, prs_pkg::BASE_ADDR | 32'h244, 32'h00001234);
    rc(prs_pkg::OFS_CHKSUM, SZW, 32'h00001234);
    wr(prs_pkg::OFS_CHKSUM, 32'hdeadbeef);
    rc(prs_pkg::OFS_CHKSUM, SZH, 32'h0000beef);
    $display("test widths done");
    wr(prs_pkg::OFS_T1_COUNT, 32'h0);
    rc(prs_pkg::OFS_T1_COUNT, SZW, 32'hffffffff);
    rc(prs_pkg::OFS_SWI_CFG, SZW, 32'h0);
    wr(12'h014, 32'hffffffff);
    rc(12'h014, SZW, 32'h0);
    acc(1'b1, SZW, 32'h00000008, 32'hffffffff);
    acc(1'b0, SZW, 32'h00000004, 32'h0);
    chk(32'h0, rd);
    rc(prs_pkg::OFS_IRQ_EN, SZW, 32'h0000ff00);
    wr(prs_pkg::OFS_T0_ACK, 32'h1);
    chk(32'h1, {29'h0, timer_irq_ack});
    wr(prs_pkg::OFS_REMAP, 32'h000000a5);
    chk(32'ha5, {24'h0, remap_out});
    rc(prs_pkg::OFS_SYNTH_STA, SZW, ~SNAP);
    $display("test access_kinds done");
    wr(prs_pkg::OFS_CLK_SEL, 32'h05);
    rc(prs_pkg::OFS_CLK_SEL, SZW, 32'h0);
    key(prs_pkg::OFS_CLK_PREKEY, prs_pkg::OFS_CLK_SEL, prs_pkg::OFS_CLK_POSTKEY, 32'h05);
    rc(prs_pkg::OFS_CLK_SEL, SZW, 32'h05);
    chk(32'h05, {24'h0, clock_sel_out});
    wr(prs_pkg::OFS_CLK_PREKEY, 32'h0);
    key(prs_pkg::OFS_CLK_SEL, prs_pkg::OFS_IRQ_EN, prs_pkg::OFS_CLK_POSTKEY, 32'h0000ff00);
    rc(prs_pkg::OFS_CLK_SEL, SZW, 32'h05);
    key(prs_pkg::OFS_POW_PREKEY, prs_pkg::OFS_POW_CTRL, prs_pkg::OFS_POW_POSTKEY, 32'h0012);
    rc(prs_pkg::OFS_POW_CTRL, SZW, 32'h0012);
    chk(32'h0012, {16'h0, power_ctrl_out});
    $display("test keyed_writes done");
    wr(prs_pkg::OFS_BOC_LOCK, 32'h0);
    chk(32'h1, {31'h0, boc_locked});
    wr(prs_pkg::OFS_BOC_UPPER, 32'h00123456);
    rc(prs_pkg::OFS_BOC_UPPER, SZW, 32'h00ffffff);
    @(posedge core_clk);
    snap <= 1'b1;
    @(posedge core_clk);
    snap <= 1'b0;
    repeat (3) @(posedge core_clk);
    rc(prs_pkg::OFS_T1_COUNT, SZW, SNAP);
    rc(prs_pkg::OFS_LPC_CNT0, SZW, {16'h0, SNAP[15:0]});
    rc(prs_pkg::OFS_BOC_STA, SZW, 32'h03);
    $display("test lock_and_capture done");
    wrap_up();
  end
endmodule
